// [pisc_pkg.sv]
`default_nettype none
package pisc_pkg;
  // Bus geometry
  localparam int PISC_AW = 12;
  localparam int PISC_DW = 32;
  localparam int PISC_WORDS = 4;

  // Pending-set words, one per group of 32 sources
  localparam logic [11:0] PISC_SET1_OFF = 12'h200;
  localparam logic [11:0] PISC_SET2_OFF = 12'h204;
  localparam logic [11:0] PISC_SET3_OFF = 12'h208;
  localparam logic [11:0] PISC_SET4_OFF = 12'h20c;

  // Pending-clear words
  localparam logic [11:0] PISC_CLR1_OFF = 12'h280;
  localparam logic [11:0] PISC_CLR2_OFF = 12'h284;
  localparam logic [11:0] PISC_CLR3_OFF = 12'h288;
  localparam logic [11:0] PISC_CLR4_OFF = 12'h28c;

  // Read-only pending view and event interrupt registers
  localparam logic [11:0] PISC_VIEW1_OFF = 12'h600;
  localparam logic [11:0] PISC_VIEW2_OFF = 12'h604;
  localparam logic [11:0] PISC_VIEW3_OFF = 12'h608;
  localparam logic [11:0] PISC_VIEW4_OFF = 12'h60c;
  localparam logic [11:0] PISC_EVT_STAT_OFF = 12'h610;
  localparam logic [11:0] PISC_EVT_MASK_OFF = 12'h614;

  // Implemented bits of each set and clear word
  localparam logic [31:0] PISC_SET1_BITS = 32'hffff_f00c;
  localparam logic [31:0] PISC_CLR1_BITS = 32'hffff_500c;
  localparam logic [31:0] PISC_FULL_BITS = 32'hffff_ffff;
  localparam logic [31:0] PISC_WORD4_BITS = 32'h0000_00ff;

  // Values after reset
  localparam logic [31:0] PISC_PEND_RST = 32'h0000_0000;
  localparam logic [3:0] PISC_EVT_RST = 4'h0;
  localparam logic [31:0] PISC_RDATA_RST = 32'h0000_0000;

  // Word index of a set or clear offset, valid only when the offset hits
  function automatic logic [1:0] pisc_word_idx(input logic [11:0] addr);
    pisc_word_idx = addr[3:2];
  endfunction

  // Mask a write word to the bits a given word implements
  function automatic logic [31:0] pisc_pick(input logic hit, input logic [31:0] data,
                                            input logic [31:0] bits);
    pisc_pick = hit ? (data & bits) : 32'h0000_0000;
  endfunction
endpackage
`default_nettype wire

// [pisc_core.sv]
// Contract
// - A write to set word two marks source 32+n pending for each one bit n, zeros do nothing.
// - A write to set word three at 0x208 marks source 64+n pending for each one bit n.
// - Bits 7..0 of set word four at 0x20C set sources 96..103, bits 31..8 are reserved zero.
// - A one in bits 31..16 of clear word one clears sources 16..31, zeros do nothing.
// - Bit 14 of clear word one clears source 14, bit 15 is reserved zero.
// - Bit 12 of clear word one clears source 12, bits 13 and 11..4 are reserved zero.
// - Bits 3..2 of clear word one clear sources 3 and 2, bits 1..0 are reserved zero.
// - A write to clear word two at 0x284 clears source 32+n for each one bit n.
// - A write to clear word three clears source 64+n for each one bit n.
// - Bits 7..0 of clear word four at 0x28C clear sources 96..103, upper bits reserved zero.
// - Set word one at 0x200 sets sources 12..31 from bits 31..12 and sources 2..3 from bits 3..2.
`timescale 1ns/1ps
`default_nettype none
module pisc_core
  import pisc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [PISC_AW-1:0] reg_addr,
  input wire logic [PISC_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [PISC_DW-1:0] reg_rdata,
  // Pending state toward arbitration, sources 0..127, 104 and up always low
  output logic [127:0] pend_flags,
  // Event interrupt
  output logic evt_irq
);

  // Per-word requests and state
  logic [31:0] pend_set_bits [PISC_WORDS];
  logic [31:0] pend_clear_bits [PISC_WORDS];
  logic [31:0] pend_reg [PISC_WORDS];
  logic [31:0] pend_next [PISC_WORDS];
  logic [3:0] evt_stat_reg;
  logic [3:0] evt_stat_next;
  logic [3:0] evt_mask_reg;
  logic [3:0] evt_rise;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic set_hit;
  logic clr_hit;
  logic [1:0] word_idx;

  // Address decode of the set and clear banks
  assign set_hit = reg_wr && (reg_addr[11:4] == PISC_SET1_OFF[11:4]);
  assign clr_hit = reg_wr && (reg_addr[11:4] == PISC_CLR1_OFF[11:4]);
  assign word_idx = pisc_word_idx(reg_addr);

  // Write words masked to the implemented sources of each word
  always_comb begin
    pend_set_bits[0] = pisc_pick(set_hit && word_idx == 2'h0, reg_wdata,
                                 PISC_SET1_BITS);
    pend_set_bits[1] = pisc_pick(set_hit && word_idx == 2'h1, reg_wdata,
                                 PISC_FULL_BITS);
    pend_set_bits[2] = pisc_pick(set_hit && word_idx == 2'h2, reg_wdata,
                                 PISC_FULL_BITS);
    pend_set_bits[3] = pisc_pick(set_hit && word_idx == 2'h3, reg_wdata,
                                 PISC_WORD4_BITS);
    pend_clear_bits[0] = pisc_pick(clr_hit && word_idx == 2'h0, reg_wdata,
                                   PISC_CLR1_BITS);
    pend_clear_bits[1] = pisc_pick(clr_hit && word_idx == 2'h1, reg_wdata,
                                   PISC_FULL_BITS);
    pend_clear_bits[2] = pisc_pick(clr_hit && word_idx == 2'h2, reg_wdata,
                                   PISC_FULL_BITS);
    pend_clear_bits[3] = pisc_pick(clr_hit && word_idx == 2'h3, reg_wdata,
                                   PISC_WORD4_BITS);
  end

  // Next pending state: hold, clear, then set on top so set wins
  always_comb begin
    for (int w = 0; w < PISC_WORDS; w++) begin
      pend_next[w] = (pend_reg[w] & ~pend_clear_bits[w]) | pend_set_bits[w];
      evt_rise[w] = |(pend_set_bits[w] & ~pend_reg[w]);
    end
  end

  // Pending flags
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int w = 0; w < PISC_WORDS; w++) begin
        pend_reg[w] <= PISC_PEND_RST;
      end
    end else begin
      for (int w = 0; w < PISC_WORDS; w++) begin
        pend_reg[w] <= pend_next[w];
      end
    end
  end

  assign pend_flags = {pend_reg[3], pend_reg[2], pend_reg[1], pend_reg[0]};

  // Sticky event bits, one per word, write one to clear, new event wins
  always_comb begin
    evt_stat_next = evt_stat_reg;
    if (reg_wr && reg_addr == PISC_EVT_STAT_OFF) begin
      evt_stat_next = evt_stat_reg & ~reg_wdata[3:0];
    end
    evt_stat_next = evt_stat_next | evt_rise;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      evt_stat_reg <= PISC_EVT_RST;
    end else begin
      evt_stat_reg <= evt_stat_next;
    end
  end

  // Event mask
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      evt_mask_reg <= PISC_EVT_RST;
    end else if (reg_wr && reg_addr == PISC_EVT_MASK_OFF) begin
      evt_mask_reg <= reg_wdata[3:0];
    end
  end

  assign evt_irq = |(evt_stat_reg & evt_mask_reg);

  // Read mux; set and clear words are write-only and read zero
  always_comb begin
    rdata_next = PISC_RDATA_RST;
    if (reg_rd) begin
      case (reg_addr)
        PISC_VIEW1_OFF: rdata_next = pend_reg[0];
        PISC_VIEW2_OFF: rdata_next = pend_reg[1];
        PISC_VIEW3_OFF: rdata_next = pend_reg[2];
        PISC_VIEW4_OFF: rdata_next = pend_reg[3];
        PISC_EVT_STAT_OFF: rdata_next = {28'h000_0000, evt_stat_reg};
        PISC_EVT_MASK_OFF: rdata_next = {28'h000_0000, evt_mask_reg};
        default: rdata_next = PISC_RDATA_RST;
      endcase
    end
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= PISC_RDATA_RST;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // Flattened requests and the addressed view word, used only by the checks below
  logic [127:0] set_all;
  logic [127:0] clr_all;
  logic [31:0] view_word;
  logic view_hit;
  logic evt_stat_hit;
  assign set_all = {pend_set_bits[3], pend_set_bits[2], pend_set_bits[1], pend_set_bits[0]};
  assign clr_all = {pend_clear_bits[3], pend_clear_bits[2], pend_clear_bits[1],
                    pend_clear_bits[0]};
  assign view_word = pend_reg[word_idx];
  assign view_hit = reg_rd && (reg_addr[11:4] == PISC_VIEW1_OFF[11:4]) &&
                    (reg_addr[1:0] == 2'h0);
  assign evt_stat_hit = reg_wr && (reg_addr == PISC_EVT_STAT_OFF);

  // Checks on the pending flags, the event bits and the read data
  default clocking pisc_cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // Set word one: implemented ones land, zero bits untouched
  set_word_one_a: assert property (reg_wr && reg_addr == PISC_SET1_OFF |=>
      ((pend_reg[0] & $past(reg_wdata) & PISC_SET1_BITS) ==
       ($past(reg_wdata) & PISC_SET1_BITS)) &&
      ((pend_reg[0] & ~$past(reg_wdata)) == ($past(pend_reg[0]) & ~$past(reg_wdata))))
    else $error("set word one did not set its sources");

  // Set word one leaves the other words still
  set_one_only_a: assert property (reg_wr && reg_addr == PISC_SET1_OFF |=>
      $stable(pend_reg[1]) && $stable(pend_reg[2]) && $stable(pend_reg[3]))
    else $error("set word one touched another word");

  // Set word two: every one lands, zeros leave their sources alone
  set_word_two_a: assert property (reg_wr && reg_addr == PISC_SET2_OFF |=>
      ((pend_reg[1] & $past(reg_wdata)) == $past(reg_wdata)) &&
      ((pend_reg[1] & ~$past(reg_wdata)) == ($past(pend_reg[1]) & ~$past(reg_wdata))))
    else $error("set word two wrong");

  // Set word two leaves the other words still
  set_two_only_a: assert property (reg_wr && reg_addr == PISC_SET2_OFF |=>
      $stable(pend_reg[0]) && $stable(pend_reg[2]) && $stable(pend_reg[3]))
    else $error("set word two touched another word");

  // Set word three: every one lands, words one and four keep still
  set_word_three_a: assert property (reg_wr && reg_addr == PISC_SET3_OFF |=>
      ((pend_reg[2] | ~$past(reg_wdata)) == PISC_FULL_BITS) &&
      $stable(pend_reg[0]) && $stable(pend_reg[3]))
    else $error("set word three wrong");

  // Set word three leaves its own zero bits alone
  set_three_keep_a: assert property (reg_wr && reg_addr == PISC_SET3_OFF |=>
      ((pend_reg[2] & ~$past(reg_wdata)) == ($past(pend_reg[2]) & ~$past(reg_wdata))))
    else $error("set word three moved a zero bit");

  // Sources 104 and up do not exist
  word_four_res_a: assert property (
      (pend_reg[3] & ~PISC_WORD4_BITS) == PISC_PEND_RST)
    else $error("reserved bits of word four became pending");

  // Set word four seen through its view on the very next read
  set_word_four_a: assert property (reg_wr && reg_addr == PISC_SET4_OFF ##1
      reg_rd && reg_addr == PISC_VIEW4_OFF |=>
      ((reg_rdata & $past(reg_wdata, 2) & PISC_WORD4_BITS) ==
       ($past(reg_wdata, 2) & PISC_WORD4_BITS)))
    else $error("set word four not visible in view");

  // Clear word one, upper half: ones clear, zeros hold
  clr_upper_a: assert property (reg_wr && reg_addr == PISC_CLR1_OFF |=>
      ((pend_reg[0][31:16] & $past(reg_wdata[31:16])) == 16'h0000) &&
      ((pend_reg[0][31:16] & ~$past(reg_wdata[31:16])) ==
       ($past(pend_reg[0][31:16]) & ~$past(reg_wdata[31:16]))))
    else $error("clear word one upper half wrong");

  // Clear word one leaves the other words still
  clr_one_only_a: assert property (reg_wr && reg_addr == PISC_CLR1_OFF |=>
      $stable(pend_reg[1]) && $stable(pend_reg[2]) && $stable(pend_reg[3]))
    else $error("clear word one touched another word");

  // Sources 14 and 12 clear, 15 and 13 have no clear bit
  clr_mid_a: assert property (reg_wr && reg_addr == PISC_CLR1_OFF |=>
      (!$past(reg_wdata[14]) || !pend_reg[0][14]) &&
      (!$past(reg_wdata[12]) || !pend_reg[0][12]) &&
      (pend_reg[0][15] == $past(pend_reg[0][15])) &&
      (pend_reg[0][13] == $past(pend_reg[0][13])))
    else $error("clear of sources 12 to 15 wrong");

  // Sources 0, 1 and 4 to 11 never pend; 3 and 2 clear
  word_one_res_a: assert property (
      ((pend_reg[0] & ~PISC_SET1_BITS) == PISC_PEND_RST) and
      (reg_wr && reg_addr == PISC_CLR1_OFF |=>
        (($past(reg_wdata[3:2]) & pend_reg[0][3:2]) == 2'h0)))
    else $error("sources 0 to 11 wrong");

  // Clear word two: ones clear, zeros hold
  clr_word_two_a: assert property (reg_wr && reg_addr == PISC_CLR2_OFF |=>
      ((pend_reg[1] & $past(reg_wdata)) == PISC_PEND_RST) &&
      ((pend_reg[1] | $past(reg_wdata)) == ($past(pend_reg[1]) | $past(reg_wdata))))
    else $error("clear word two wrong");

  // Clear word three
  clr_word_three_a: assert property (reg_wr && reg_addr == PISC_CLR3_OFF |=>
      ((pend_reg[2] & $past(reg_wdata)) == PISC_PEND_RST) && $stable(pend_reg[1]))
    else $error("clear word three wrong");

  // Clear word four
  clr_word_four_a: assert property (reg_wr && reg_addr == PISC_CLR4_OFF |=>
      ((pend_reg[3] & $past(reg_wdata) & PISC_WORD4_BITS) == PISC_PEND_RST))
    else $error("clear word four wrong");

  // Clear word four leaves its own zero bits alone
  clr_four_keep_a: assert property (reg_wr && reg_addr == PISC_CLR4_OFF |=>
      ((pend_reg[3] | $past(reg_wdata)) == ($past(pend_reg[3]) | $past(reg_wdata))))
    else $error("clear word four moved a zero bit");

  // Flags hold with no set or clear write
  pend_hold_a: assert property (!set_hit && !clr_hit |=> $stable(pend_flags))
    else $error("pending flag moved without a write");

  // Any set request lands on the next edge, whatever the clear side asks
  set_wins_a: assert property (|set_all |=>
      ((pend_flags & $past(set_all)) == $past(set_all)))
    else $error("a set request did not land");

  // A clear with no set beside it removes the flag
  clr_lands_a: assert property (|clr_all |=>
      ((pend_flags & $past(clr_all) & ~$past(set_all)) == 128'h0))
    else $error("a clear request did not land");

  // A write of zeros to a set or clear word changes nothing
  zero_write_a: assert property (
      (set_hit || clr_hit) && reg_wdata == 32'h0000_0000 |=> $stable(pend_flags))
    else $error("a write of zeros moved a flag");

  // Set and clear words are write-only and read zero
  wo_read_zero_a: assert property (
      reg_rd && (reg_addr[11:4] == PISC_SET1_OFF[11:4] ||
                 reg_addr[11:4] == PISC_CLR1_OFF[11:4]) |=> reg_rdata == PISC_RDATA_RST)
    else $error("a write-only word read nonzero");

  // A view read returns the pending word as it stood when the strobe was taken
  view_read_a: assert property (view_hit |=> reg_rdata == $past(view_word))
    else $error("view read returned the wrong word");

  // Every other read answers zero
  other_read_a: assert property (reg_rd && !view_hit && reg_addr != PISC_EVT_STAT_OFF &&
      reg_addr != PISC_EVT_MASK_OFF |=> reg_rdata == PISC_RDATA_RST)
    else $error("read outside the map returned data");

  // Event status reads back in its low four bits
  evt_read_a: assert property (reg_rd && reg_addr == PISC_EVT_STAT_OFF |=>
      reg_rdata == {28'h000_0000, $past(evt_stat_reg)})
    else $error("event status read wrong");

  // Event mask reads back in its low four bits
  mask_read_a: assert property (reg_rd && reg_addr == PISC_EVT_MASK_OFF |=>
      reg_rdata == {28'h000_0000, $past(evt_mask_reg)})
    else $error("event mask read wrong");

  // A set that makes a new source of a word pending raises that word's event
  evt_set_a: assert property (set_hit |=> (evt_stat_reg & $past(evt_rise)) == $past(evt_rise))
    else $error("event bit not raised");

  // Writing ones to the status clears those bits
  evt_clear_a: assert property (evt_stat_hit |=>
      (evt_stat_reg & $past(reg_wdata[3:0])) == 4'h0)
    else $error("event bit not cleared");

  // Without a set or a status write the event bits hold
  evt_hold_a: assert property (!set_hit && !evt_stat_hit |=> $stable(evt_stat_reg))
    else $error("event bit moved on its own");

  // The mask takes the written value
  mask_write_a: assert property (reg_wr && reg_addr == PISC_EVT_MASK_OFF |=>
      evt_mask_reg == $past(reg_wdata[3:0]))
    else $error("event mask not written");

  // An unmasked new event shows on the interrupt line one cycle later
  irq_level_a: assert property (set_hit && |(evt_rise & evt_mask_reg) |=> evt_irq)
    else $error("event interrupt out of step");

  // A cleared mask silences the line
  irq_mask_a: assert property (reg_wr && reg_addr == PISC_EVT_MASK_OFF &&
      reg_wdata[3:0] == 4'h0 |=> !evt_irq)
    else $error("masked event still drives the line");

  // Read data return to zero outside the answer cycle
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == PISC_RDATA_RST)
    else $error("read data outside read cycle");

  // Main scenarios
  set_then_clr_c: cover property (reg_wr && reg_addr == PISC_SET2_OFF && reg_wdata[0]
      ##1 reg_wr && reg_addr == PISC_CLR2_OFF && reg_wdata[0] ##1 !pend_reg[1][0]);
  irq_raise_c: cover property (!evt_irq ##1 evt_irq);
  view_read_c: cover property (reg_rd && reg_addr == PISC_VIEW1_OFF ##1 reg_rdata != 32'h0);
  word_four_c: cover property (reg_wr && reg_addr == PISC_SET4_OFF ##1 pend_reg[3] != 32'h0);
  evt_clear_c: cover property (|evt_stat_reg ##1 evt_stat_hit
      ##1 evt_stat_reg == 4'h0);

endmodule // pisc_core
`default_nettype wire

// [pisc_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pisc_cpu_model
  import pisc_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Register port toward the block
  output logic [PISC_AW-1:0] reg_addr,
  output logic [PISC_DW-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // Quiet bus at time zero
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One access, taken at the next edge; strobes stay up so accesses can run back to back
  task automatic access(input logic wr, input logic [PISC_AW-1:0] a,
                        input logic [PISC_DW-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge sys_clk);
  endtask

  // Release strobes; stale address and data flip so the block cannot lean on them
  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~reg_addr;
    reg_wdata <= ~reg_wdata;
    @(posedge sys_clk);
  endtask
endmodule // pisc_cpu_model
`default_nettype wire

// [test_pisc_core.sv]
`timescale 1ns/1ps
`default_nettype none
module test_pisc_core;
  import pisc_pkg::*;
  logic sys_clk;
  logic reset_n = 1'b0;
  logic [PISC_AW-1:0] reg_addr;
  logic [PISC_DW-1:0] reg_wdata;
  logic [PISC_DW-1:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic evt_irq;
  logic rd_taken = 1'b0;
  logic [127:0] pend_flags;
  logic [127:0] exp_pend = '0;
  logic [3:0] exp_stat = '0;
  logic [3:0] exp_mask = '0;
  logic [31:0] exp_q[$];
  logic [31:0] r;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;

  // Block and the core model that drives its register port
  pisc_core i_pisc_core (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pend_flags(pend_flags), .evt_irq(evt_irq));
  pisc_cpu_model i_pisc_cpu_model (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // Clock, 40 ns period
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Compare and count
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Writable bits of each set or clear word
  function automatic logic [31:0] word_bits(input int w, input logic clr);
    if (w == 3) return 32'h0000_00ff;
    if (w > 0) return 32'hffff_ffff;
    return clr ? 32'hffff_500c : 32'hffff_f00c;
  endfunction

  // Write and keep the expected pending and event state in step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] m;
    int w;
    w = a[3:2];
    i_pisc_cpu_model.access(1'b1, a, d);
    m = d & word_bits(w, a[7]);
    if (a[11:4] == 8'h20) begin
      exp_stat[w] |= |(m & ~exp_pend[w*32 +: 32]);
      exp_pend[w*32 +: 32] |= m;
    end else if (a[11:4] == 8'h28) exp_pend[w*32 +: 32] &= ~m;
    else if (a == PISC_EVT_STAT_OFF) exp_stat &= ~d[3:0];
    else if (a == PISC_EVT_MASK_OFF) exp_mask = d[3:0];
  endtask

  // Read: note the expected word, the watcher compares it
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_pisc_cpu_model.access(1'b0, a, '0);
  endtask

  // Cycle count with a ceiling against hangs
  always @(posedge sys_clk) begin
    rd_taken <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  // Watcher: outputs are settled at the falling edge
  always @(negedge sys_clk) begin
    if (rd_taken && exp_q.size() > 0) check(reg_rdata, exp_q.pop_front());
    else check(reg_rdata, '0);
    check(pend_flags, exp_pend);
    check(evt_irq, |(exp_stat & exp_mask));
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    void'($urandom(32'h1b18));
    @(posedge sys_clk);
    wr(PISC_EVT_MASK_OFF, 32'hf);
    // Every bit of word one and word four, reserved ones included
    wr(PISC_SET1_OFF, '1);
    wr(PISC_SET4_OFF, '1);
    rd(PISC_VIEW4_OFF, 32'h0000_00ff);
    wr(PISC_CLR4_OFF, 32'hffff_ff00);
    wr(PISC_CLR1_OFF, '1);
    rd(PISC_VIEW1_OFF, 32'h0000_a000);
    rd(PISC_VIEW4_OFF, 32'h0000_00ff);
    wr(PISC_CLR4_OFF, 32'h0000_00ff);
    rd(PISC_VIEW4_OFF, '0);
    idle_bus();
    // Write-only words and an unmapped place read zero
    for (int i = 0; i < 8; i++) rd({4'h2, i[2], 3'h0, i[1:0], 2'h0}, '0);
    rd(12'h7f0, '0);
    wr(12'h7f0, '1);
    // Zero writes move nothing
    wr(PISC_SET3_OFF, '0);
    wr(PISC_CLR2_OFF, '0);
    idle_bus();
    // Random set and clear traffic, read back at once
    for (int k = 0; k < 80; k++) begin
      r = $urandom;
      wr({4'h2, r[0], 3'h0, r[2:1], 2'h0}, $urandom);
      rd(PISC_VIEW1_OFF + {r[2:1], 2'h0}, exp_pend[r[2:1]*32 +: 32]);
      if (r[3]) idle_bus();
    end
    // Event interrupt: raise, mask, clear
    wr(PISC_EVT_MASK_OFF, 32'h2);
    wr(PISC_CLR2_OFF, '1);
    wr(PISC_EVT_STAT_OFF, 32'hf);
    wr(PISC_SET2_OFF, 32'h1);
    rd(PISC_EVT_STAT_OFF, 32'h2);
    rd(PISC_EVT_MASK_OFF, 32'h2);
    wr(PISC_EVT_MASK_OFF, '0);
    wr(PISC_EVT_STAT_OFF, 32'h2);
    rd(PISC_EVT_STAT_OFF, '0);
    idle_bus();
    repeat (2) @(posedge sys_clk);
    give_verdict();
  end

  task automatic idle_bus();
    i_pisc_cpu_model.idle();
  endtask
endmodule // test_pisc_core
`default_nettype wire
